// File: shared/cot_pkg.sv
package cot_pkg;

    // ----------------------------------------------------------------
    // bus and pin geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned PIN_COUNT   = 37;
    localparam logic [5:0]  PIN_SEL_OFF = 6'h00;
    localparam logic [5:0]  PIN_SEL_MAX = 6'h25;
    // two synchroniser flops plus the edge-detect flop give the documented 3-cycle input lag
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned INPUT_LAG   = SYNC_STAGES + 1;

    // ----------------------------------------------------------------
    // register map: printed offsets; slot = offset - base, byte address = 4 * slot
    // ----------------------------------------------------------------
    localparam logic [31:0] REG_BASE           = 32'h50000200;
    localparam logic [31:0] OFS_CONTROL        = 32'h50000200;
    localparam logic [31:0] OFS_COUNT_LOW      = 32'h50000202;
    localparam logic [31:0] OFS_STATE          = 32'h50000204;
    localparam logic [31:0] OFS_SEL_A          = 32'h50000206;
    localparam logic [31:0] OFS_SEL_B          = 32'h50000208;
    localparam logic [31:0] OFS_RELOAD_LOW     = 32'h5000020A;
    localparam logic [31:0] OFS_WIDTH_LOW      = 32'h5000020C;
    localparam logic [31:0] OFS_DIVIDER        = 32'h5000020E;
    localparam logic [31:0] OFS_LATCH_A_LOW    = 32'h50000210;
    localparam logic [31:0] OFS_LATCH_B_LOW    = 32'h50000212;
    localparam logic [31:0] OFS_DIVIDER_NOW    = 32'h50000214;
    localparam logic [31:0] OFS_PWM_PERIOD     = 32'h50000216;
    localparam logic [31:0] OFS_PWM_DUTY       = 32'h50000218;
    localparam logic [31:0] OFS_COUNT_HIGH     = 32'h5000021A;
    localparam logic [31:0] OFS_RELOAD_HIGH    = 32'h5000021C;
    localparam logic [31:0] OFS_LATCH_A_HIGH   = 32'h5000021E;
    localparam logic [31:0] OFS_LATCH_B_HIGH   = 32'h50000220;
    localparam logic [31:0] OFS_WIDTH_HIGH     = 32'h50000222;
    localparam logic [15:0] RESET_VALUE        = 16'h0000;

    // ----------------------------------------------------------------
    // field layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic fastClockSelect;
        logic wrapAtMaxEnable;
        logic interruptUnmask;
        logic edgeSelectBit4;
        logic edgeSelectBit3;
        logic countDirectionDown;
        logic singlePulseMode;
        logic timerEnable;
    } cot_ctrl_s;

    localparam int unsigned STATE_PHASE_LSB = 2;
    localparam int unsigned STATE_LEVEL_A   = 1;
    localparam int unsigned STATE_LEVEL_B   = 0;

    typedef enum {PH_WAIT, PH_DELAY, PH_START, PH_SHOT} cot_phase_e;

    function automatic logic [5:0] regSlot(input logic [31:0] ofs);
        logic [31:0] diff;
        diff    = ofs - REG_BASE;
        regSlot = diff[5:0];
    endfunction

endpackage

// File: src/cot_sync.sv
`timescale 1ns/100ps
module cot_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  logic             clock,
    input  logic             nrst,
    input  logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    // first stage is read only by the second
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else
        begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule // cot_sync

// File: src/cot_timer.sv
// Function
// - bit 7 picks system or slow clock
// - bit 6 makes free-run up count wrap only at max, else at reload
// - bit 5 unmasks the interrupt request
// - bit 4 selects falling edge, input a
// - bit 3 selects falling edge, input b
// - bit 2 makes free-run counter count down
// - bit 1 selects one-shot pulse mode
// - bit 0 enables the timer
// - read-only counter value, resets to zero
// - status bits 3:2 show sequencer phase
// - status bits 1:0 show input levels
// - one pin select register per input
// - reload doubles as one-shot delay length
// - separate register sets shot length
// - prescaler divides the selected clock
// - input events latch counter into captures
// - period and duty registers shape PWM
// - high registers extend 16-bit values
// - count rate is clock over prescaler+1
// - delay adds three cycles input synchronisation
// - PWM rate period+1, duty over period+1
// - select 1..37 picks pin, 0 disables
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module cot_timer (
    input  logic                          clock,
    input  logic                          nrst,
    input  logic                          psel,
    input  logic                          penable,
    input  logic                          pwrite,
    input  logic [cot_pkg::ADDR_W-1:0]    paddr,
    input  logic [31:0]                   pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  logic [cot_pkg::PIN_COUNT-1:0] gpioPins,
    input  logic                          slowClock,
    output logic                          interruptRequest,
    output logic                          pulseOut,
    output logic                          pwmOut
);
    import cot_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisation and pin selection
    // ----------------------------------------------------------------
    logic [PIN_COUNT:0]   rawIn;
    logic [PIN_COUNT:0]   syncIn;
    logic [5:0]           selA_r;
    logic [5:0]           selB_r;
    logic                 levelA;
    logic                 levelB;
    logic                 levelA_r;
    logic                 levelB_r;
    logic                 slow_r;
    cot_ctrl_s            ctrl_r;

    assign rawIn = {slowClock, gpioPins};

    cot_sync #(.WIDTH(PIN_COUNT + 1)) u_sync (
        .clock   (clock),
        .nrst    (nrst),
        .asyncIn (rawIn),
        .syncOut (syncIn)
    );

    function automatic logic pickPin(input logic [PIN_COUNT-1:0] pins, input logic [5:0] sel);
        logic [5:0] idx;
        idx     = sel - 6'h01;
        pickPin = 1'b0;
        if (sel != PIN_SEL_OFF && sel <= PIN_SEL_MAX)
            pickPin = pins[idx];
    endfunction

    assign levelA = pickPin(syncIn[PIN_COUNT-1:0], selA_r);
    assign levelB = pickPin(syncIn[PIN_COUNT-1:0], selB_r);

    logic enable;
    logic eventA;
    logic eventB;
    logic slowRise;

    assign enable   = ctrl_r.timerEnable;
    assign eventA   = enable && (ctrl_r.edgeSelectBit4 ? (levelA_r && !levelA) : (!levelA_r && levelA));
    assign eventB   = enable && (ctrl_r.edgeSelectBit3 ? (levelB_r && !levelB) : (!levelB_r && levelB));
    assign slowRise = syncIn[PIN_COUNT] && !slow_r;

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    logic [15:0] divider_r;
    logic [15:0] prescCnt_r;
    logic [15:0] prescCnt_nxt;
    logic        srcTick;
    logic        tick;
    logic        divWr;

    assign srcTick      = ctrl_r.fastClockSelect || slowRise;
    // one tick per divider+1 source ticks
    assign tick         = enable && srcTick && (prescCnt_r == divider_r);
    // a new divider restarts the count, else a smaller value would stall until wrap
    assign prescCnt_nxt = (!enable || divWr) ? 16'h0000 : !srcTick ? prescCnt_r : tick ? 16'h0000 :
                          prescCnt_r + 16'h0001;

    // ----------------------------------------------------------------
    // counter and one-shot sequencer
    // ----------------------------------------------------------------
    logic [15:0] reloadLo_r;
    logic [15:0] reloadHi_r;
    logic [15:0] widthLo_r;
    logic [15:0] widthHi_r;
    logic [31:0] reload32;
    logic [31:0] width32;
    logic [31:0] counter_r;
    logic [31:0] counter_nxt;
    logic [31:0] countInc;
    cot_phase_e  phase_r;
    cot_phase_e  phase_nxt;
    logic        terminalEv;

    // high halves extend the low registers
    assign reload32 = {reloadHi_r, reloadLo_r};
    assign width32  = {widthHi_r, widthLo_r};
    assign countInc = counter_r + 32'h00000001;

    function automatic logic [1:0] phaseCode(input cot_phase_e ph);
        unique case (ph)
            PH_WAIT:  phaseCode = 2'h0;
            PH_DELAY: phaseCode = 2'h1;
            PH_START: phaseCode = 2'h2;
            PH_SHOT:  phaseCode = 2'h3;
        endcase
    endfunction

    always_comb
    begin
        counter_nxt = counter_r;
        phase_nxt   = phase_r;
        terminalEv  = 1'b0;
        // disabled timer holds its value and returns to wait
        if (!enable)
            phase_nxt = PH_WAIT;
        else if (ctrl_r.singlePulseMode)
        begin
            unique case (phase_r)
                PH_WAIT:
                begin
                    counter_nxt = 32'h00000000;
                    if (eventA || eventB)
                        phase_nxt = PH_DELAY;
                end
                PH_DELAY:
                begin
                    // reload+1 ticks after the synchronised event
                    if (tick && counter_r == reload32)
                    begin
                        counter_nxt = 32'h00000000;
                        phase_nxt   = PH_START;
                    end
                    else if (tick)
                        counter_nxt = countInc;
                end
                PH_START:
                begin
                    if (tick)
                        phase_nxt = PH_SHOT;
                end
                PH_SHOT:
                begin
                    if (tick && counter_r == width32)
                    begin
                        counter_nxt = 32'h00000000;
                        phase_nxt   = PH_WAIT;
                        terminalEv  = 1'b1;
                    end
                    else if (tick)
                        counter_nxt = countInc;
                end
            endcase
        end
        else
        begin
            phase_nxt = PH_WAIT;
            if (tick && ctrl_r.countDirectionDown)
            begin
                terminalEv  = (counter_r == 32'h00000000);
                counter_nxt = terminalEv ? reload32 : counter_r - 32'h00000001;
            end
            else if (tick)
            begin
                terminalEv  = ctrl_r.wrapAtMaxEnable ? (&counter_r) : (counter_r == reload32);
                counter_nxt = terminalEv ? 32'h00000000 : countInc;
            end
        end
    end

    // ----------------------------------------------------------------
    // captures, pwm, outputs
    // ----------------------------------------------------------------
    logic [31:0] capA_r;
    logic [31:0] capB_r;
    logic [15:0] pwmPeriod_r;
    logic [15:0] pwmDuty_r;
    logic [15:0] pwmCnt_r;
    logic [15:0] pwmCnt_nxt;
    logic        irq_nxt;
    logic        pulse_nxt;

    // pwm counter runs over period+1 ticks
    assign pwmCnt_nxt = !enable ? 16'h0000 : !tick ? pwmCnt_r : (pwmCnt_r == pwmPeriod_r) ? 16'h0000 :
                        pwmCnt_r + 16'h0001;
    assign irq_nxt    = ctrl_r.interruptUnmask && (eventA || eventB || terminalEv);
    assign pulse_nxt  = (phase_nxt == PH_START) || (phase_nxt == PH_SHOT);

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            levelA_r         <= 1'b0;
            levelB_r         <= 1'b0;
            slow_r           <= 1'b0;
            prescCnt_r       <= RESET_VALUE;
            counter_r        <= 32'h00000000;
            phase_r          <= PH_WAIT;
            pwmCnt_r         <= RESET_VALUE;
            interruptRequest <= 1'b0;
            pulseOut         <= 1'b0;
            pwmOut           <= 1'b0;
        end
        else
        begin
            levelA_r         <= levelA;
            levelB_r         <= levelB;
            slow_r           <= syncIn[PIN_COUNT];
            prescCnt_r       <= prescCnt_nxt;
            counter_r        <= counter_nxt;
            phase_r          <= phase_nxt;
            pwmCnt_r         <= pwmCnt_nxt;
            interruptRequest <= irq_nxt;
            pulseOut         <= pulse_nxt;
            pwmOut           <= enable && (pwmCnt_r < pwmDuty_r);
        end
    end

    // latch counter on each input event
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            capA_r <= 32'h00000000;
            capB_r <= 32'h00000000;
        end
        else
        begin
            if (eventA)
                capA_r <= counter_r;
            if (eventB)
                capB_r <= counter_r;
        end
    end

    // ----------------------------------------------------------------
    // apb slave: one wait state, answers from flops
    // ----------------------------------------------------------------
    logic [5:0]  slot;
    logic        addrOk;
    logic        readHit;
    logic [15:0] readWord;
    logic        accessEnd;
    logic        wrEn;
    logic        pready_nxt;
    logic [15:0] stateWord;

    assign slot       = paddr[7:2];
    assign addrOk     = readHit && (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:8] == '0);
    assign accessEnd  = psel && penable && pready;
    assign wrEn       = accessEnd && pwrite && addrOk;
    assign divWr      = wrEn && (slot == regSlot(OFS_DIVIDER));
    assign pready_nxt = psel && penable && !pready;
    assign stateWord  = {12'h000, phaseCode(phase_r), levelA_r, levelB_r};

    always_comb
    begin
        readHit = 1'b1;
        unique case (slot)
            regSlot(OFS_CONTROL):      readWord = {8'h00, ctrl_r};
            regSlot(OFS_COUNT_LOW):    readWord = counter_r[15:0];
            regSlot(OFS_STATE):        readWord = stateWord;
            regSlot(OFS_SEL_A):        readWord = {10'h000, selA_r};
            regSlot(OFS_SEL_B):        readWord = {10'h000, selB_r};
            regSlot(OFS_RELOAD_LOW):   readWord = reloadLo_r;
            regSlot(OFS_WIDTH_LOW):    readWord = widthLo_r;
            regSlot(OFS_DIVIDER):      readWord = divider_r;
            regSlot(OFS_LATCH_A_LOW):  readWord = capA_r[15:0];
            regSlot(OFS_LATCH_B_LOW):  readWord = capB_r[15:0];
            regSlot(OFS_DIVIDER_NOW):  readWord = prescCnt_r;
            regSlot(OFS_PWM_PERIOD):   readWord = pwmPeriod_r;
            regSlot(OFS_PWM_DUTY):     readWord = pwmDuty_r;
            regSlot(OFS_COUNT_HIGH):   readWord = counter_r[31:16];
            regSlot(OFS_RELOAD_HIGH):  readWord = reloadHi_r;
            regSlot(OFS_LATCH_A_HIGH): readWord = capA_r[31:16];
            regSlot(OFS_LATCH_B_HIGH): readWord = capB_r[31:16];
            regSlot(OFS_WIDTH_HIGH):   readWord = widthHi_r;
            default:
            begin
                readHit  = 1'b0;
                readWord = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= pready_nxt;
            pslverr <= pready_nxt && !addrOk;
            prdata  <= (pready_nxt && !pwrite && addrOk) ? {16'h0000, readWord} : 32'h00000000;
        end
    end

    // writable registers; read-only slots ignore writes
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r      <= '0;
            selA_r      <= 6'h00;
            selB_r      <= 6'h00;
            reloadLo_r  <= RESET_VALUE;
            reloadHi_r  <= RESET_VALUE;
            widthLo_r   <= RESET_VALUE;
            widthHi_r   <= RESET_VALUE;
            divider_r   <= RESET_VALUE;
            pwmPeriod_r <= RESET_VALUE;
            pwmDuty_r   <= RESET_VALUE;
        end
        else if (wrEn)
        begin
            if (slot == regSlot(OFS_CONTROL))     ctrl_r      <= pwdata[7:0];
            if (slot == regSlot(OFS_SEL_A))       selA_r      <= pwdata[5:0];
            if (slot == regSlot(OFS_SEL_B))       selB_r      <= pwdata[5:0];
            if (slot == regSlot(OFS_RELOAD_LOW))  reloadLo_r  <= pwdata[15:0];
            if (slot == regSlot(OFS_RELOAD_HIGH)) reloadHi_r  <= pwdata[15:0];
            if (slot == regSlot(OFS_WIDTH_LOW))   widthLo_r   <= pwdata[15:0];
            if (slot == regSlot(OFS_WIDTH_HIGH))  widthHi_r   <= pwdata[15:0];
            if (slot == regSlot(OFS_DIVIDER))     divider_r   <= pwdata[15:0];
            if (slot == regSlot(OFS_PWM_PERIOD))  pwmPeriod_r <= pwdata[15:0];
            if (slot == regSlot(OFS_PWM_DUTY))    pwmDuty_r   <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence seqStart;
        phase_r == PH_START && enable && ctrl_r.singlePulseMode;
    endsequence

    sequence seqShot;
        phase_r == PH_SHOT && pulseOut;
    endsequence

    fast_count_up_a: assert property (ctrl_r.fastClockSelect && divider_r == 16'h0000 && enable
        && !ctrl_r.singlePulseMode && !ctrl_r.countDirectionDown && counter_r != reload32 && !(&counter_r)
        |=> counter_r == $past(counter_r) + 32'h00000001)
        else $error("fast clock did not advance counter");
    free_run_wrap_a: assert property (tick && !ctrl_r.singlePulseMode && !ctrl_r.countDirectionDown
        && ctrl_r.wrapAtMaxEnable && counter_r == reload32 && !(&counter_r) |=> counter_r != 32'h00000000)
        else $error("free-run counter cleared at reload");
    irq_masked_a: assert property (!ctrl_r.interruptUnmask |=> !interruptRequest)
        else $error("masked interrupt raised");
    count_down_a: assert property (tick && !ctrl_r.singlePulseMode && ctrl_r.countDirectionDown
        && counter_r != 32'h00000000 |=> counter_r == $past(counter_r) - 32'h00000001)
        else $error("down count wrong");
    disabled_hold_a: assert property (!enable |=> $stable(counter_r) && !pwmOut)
        else $error("disabled timer moved");
    capture_a_a: assert property (eventA |=> capA_r == $past(counter_r) && interruptRequest == $past(irq_nxt))
        else $error("capture a did not latch counter");
    presc_rate_a: assert property (tick |-> prescCnt_r == divider_r ##1 prescCnt_r == 16'h0000)
        else $error("prescaler tick out of step");
    shot_follows_a: assert property (seqStart ##0 tick |=> seqShot)
        else $error("shot phase did not follow start");
    wait_to_delay_a: assert property (phase_r == PH_WAIT && ctrl_r.singlePulseMode && (eventA || eventB)
        |=> stateWord[STATE_PHASE_LSB +: 2] == 2'h1)
        else $error("event did not start delay phase");
    apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule // cot_timer

// File: testbench/cot_pin_model.sv
`timescale 1ns/100ps
module cot_pin_model (
    input  logic                          clock,
    input  logic [5:0]                    drivePin,
    input  logic                          driveLevel,
    output logic [cot_pkg::PIN_COUNT-1:0] gpioPins,
    output logic                          slowClock
);
    import cot_pkg::*;
    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    logic [3:0] slowDiv_r = 4'h0;
    logic       noise_r   = 1'b0;
    // pins nobody drives toggle every cycle, so a wrong pin select floods the design with edges
    always_ff @(posedge clock)
    begin
        noise_r   <= ~noise_r;
        slowDiv_r <= slowDiv_r + 4'h1;
    end
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
            gpioPins[i] = (drivePin == 6'(i + 1)) ? driveLevel : noise_r;
    end
    // slow clock free runs at one sixteenth of the system clock to keep the run short
    assign slowClock = slowDiv_r[3];
endmodule // cot_pin_model

// File: testbench/tb_capture_oneshot_timer.sv
`timescale 1ns/100ps
module tb_capture_oneshot_timer;
    import cot_pkg::*;
    // ----------------------------------------------------------------
    // harness
    // ----------------------------------------------------------------
    logic                 clock, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic                 slowClock, interruptRequest, pulseOut, pwmOut, driveLevel;
    logic [ADDR_W-1:0]    paddr;
    logic [31:0]          pwdata, prdata, rd, held;
    logic [PIN_COUNT-1:0] gpioPins;
    logic [5:0]           drivePin;
    int                   n_mismatch, num_checks, cycles, s4, s8, h4, h8;

    cot_timer DUT (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpioPins(gpioPins), .slowClock(slowClock), .interruptRequest(interruptRequest),
        .pulseOut(pulseOut), .pwmOut(pwmOut));
    cot_pin_model pins (.clock(clock), .drivePin(drivePin), .driveLevel(driveLevel),
        .gpioPins(gpioPins), .slowClock(slowClock));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    function automatic logic [5:0] sl(input logic [31:0] ofs);
        logic [31:0] d;
        d = ofs - REG_BASE;
        return d[5:0];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] ofs, input logic [15:0] wd);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {4'h0, sl(ofs), 2'b00};
        pwdata  <= {16'h0000, wd};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic edgeIrq(input logic lvl, input int exp);
        int cnt;
        cnt = 0;
        @(posedge clock);
        driveLevel <= lvl;
        repeat (12)
        begin
            @(posedge clock);
            if (interruptRequest === 1'b1)
                cnt++;
        end
        chk(cnt, exp);
    endtask
    task automatic shot(input logic [15:0] rl, output int start, output int hi);
        apb(1'b1, OFS_RELOAD_LOW, rl);
        start = 0;
        hi = 0;
        @(posedge clock);
        driveLevel <= 1'b1;
        for (int i = 0; i < 60; i++)
        begin
            @(posedge clock);
            if (pulseOut === 1'b1 && hi++ == 0)
                start = i;
        end
        driveLevel <= 1'b0;
        apb(1'b0, OFS_STATE, 16'h0000);
        chk(rd[3:2], 0);
    endtask
    task automatic pwmRun(input logic [15:0] ctl, input logic [15:0] div, input int win, input int eh, input int er);
        int hi, rs;
        logic last;
        apb(1'b1, OFS_DIVIDER, div);
        apb(1'b1, OFS_CONTROL, ctl);
        repeat (70) @(posedge clock);
        hi = 0;
        rs = 0;
        last = pwmOut;
        repeat (win)
        begin
            @(posedge clock);
            hi += (pwmOut === 1'b1);
            rs += (pwmOut === 1'b1 && last === 1'b0);
            last = pwmOut;
        end
        chk(hi, eh);
        chk(rs, er);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic tResetAndMap();
        apb(1'b0, OFS_COUNT_LOW, 16'h0000);
        chk(rd, 0);
        apb(1'b0, OFS_STATE, 16'h0000);
        chk(rd, 0);
        apb(1'b0, REG_BASE + 32'h24, 16'h0000);
        chk(err, 1'b1);
        apb(1'b1, OFS_CONTROL, 16'h00A4);
        apb(1'b0, OFS_CONTROL, 16'h0000);
        chk(rd, 32'h000000A4);
    endtask
    task automatic tCount();
        apb(1'b1, OFS_RELOAD_LOW, 16'h0005);
        apb(1'b1, OFS_CONTROL, 16'h0081);
        repeat (6)
        begin
            apb(1'b0, OFS_COUNT_LOW, 16'h0000);
            chk(rd <= 32'h5, 1'b1);
        end
        apb(1'b1, OFS_CONTROL, 16'h00C1);
        repeat (20) @(posedge clock);
        apb(1'b0, OFS_COUNT_LOW, 16'h0000);
        chk(rd > 32'h5, 1'b1);
        apb(1'b1, OFS_CONTROL, 16'h00C0);
        apb(1'b0, OFS_COUNT_LOW, 16'h0000);
        held = rd;
        apb(1'b0, OFS_COUNT_LOW, 16'h0000);
        chk(rd, held);
    endtask
    task automatic tCapture();
        apb(1'b1, OFS_SEL_A, 16'h0003);
        apb(1'b1, OFS_CONTROL, 16'h00E1);
        edgeIrq(1'b1, 1);
        apb(1'b0, OFS_STATE, 16'h0000);
        chk(rd[STATE_LEVEL_A], 1'b1);
        apb(1'b0, OFS_LATCH_A_LOW, 16'h0000);
        chk(rd > 32'h5, 1'b1);
        edgeIrq(1'b0, 0);
        apb(1'b1, OFS_CONTROL, 16'h00F1);
        edgeIrq(1'b1, 0);
        edgeIrq(1'b0, 1);
        apb(1'b1, OFS_CONTROL, 16'h00D1);
        edgeIrq(1'b1, 0);
        edgeIrq(1'b0, 0);
        apb(1'b1, OFS_CONTROL, 16'h00F1);
        apb(1'b1, OFS_SEL_A, 16'h0000);
        edgeIrq(1'b1, 0);
        edgeIrq(1'b0, 0);
        apb(1'b1, OFS_SEL_B, 16'h0003);
        apb(1'b1, OFS_CONTROL, 16'h00E9);
        edgeIrq(1'b1, 0);
        apb(1'b0, OFS_STATE, 16'h0000);
        chk(rd[STATE_LEVEL_B], 1'b1);
        edgeIrq(1'b0, 1);
        apb(1'b0, OFS_LATCH_B_LOW, 16'h0000);
        chk(rd > 32'h5, 1'b1);
    endtask
    task automatic tOneShot();
        apb(1'b1, OFS_SEL_A, 16'h0003);
        apb(1'b1, OFS_WIDTH_LOW, 16'h0003);
        apb(1'b1, OFS_CONTROL, 16'h0083);
        shot(16'h0004, s4, h4);
        shot(16'h0008, s8, h8);
        chk(h4, 5);
        chk(h8, 5);
        chk(s8 - s4, 4);
    endtask

    initial
    begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        drivePin = 6'h03;
        driveLevel = 1'b0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        tResetAndMap();
        tCount();
        tCapture();
        tOneShot();
        apb(1'b1, OFS_PWM_PERIOD, 16'h0003);
        apb(1'b1, OFS_PWM_DUTY, 16'h0001);
        pwmRun(16'h0081, 16'h0000, 48, 12, 12);
        pwmRun(16'h0081, 16'h0001, 48, 12, 6);
        pwmRun(16'h0001, 16'h0000, 128, 32, 2);
        tally_and_finish();
    end
endmodule // tb_capture_oneshot_timer
